// [src/psr_chan_pacer.sv]
/*
  Per-channel occupancy timer: one message holds the channel for a frame.
  Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ps
`default_nettype none

module psr_chan_pacer #(
  parameter int unsigned FAST_CYC = psr_pkg::FRAME_FAST_CYC,
  parameter int unsigned SLOW_CYC = psr_pkg::FRAME_SLOW_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rate_fast,
  input wire logic start,
  output var logic busy
);
  import psr_pkg::*;

  localparam logic [TMR_W-1:0] FAST_LEN = TMR_W'(FAST_CYC);
  localparam logic [TMR_W-1:0] SLOW_LEN = TMR_W'(SLOW_CYC);

  logic [TMR_W-1:0] remain;

  // ------------------------------------------------------------
  // Frame time; this is the store-and-forward delay of one hop
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= '0;
      busy <= 1'b0;
    end else if (start) begin
      remain <= rate_fast ? FAST_LEN - 1'b1 : SLOW_LEN - 1'b1; // [R16]
      busy <= 1'b1;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end else begin
      busy <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_frame_len;
    @(posedge sys_clk) disable iff (!rst_n)
    start && rate_fast |=> remain == FAST_LEN - 1'b1 && busy;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // [R16]

  property p_no_early_free;
    @(posedge sys_clk) disable iff (!rst_n)
    remain != '0 |=> busy;
  endproperty
  a_no_early_free: assert property (p_no_early_free) else $error("channel freed early");

endmodule

`default_nettype wire

// [src/psr_messenger.sv]
/*
  Peer status ring messenger: sends own status messages, forwards others,
  watches for own returns and for silent peers.
  Assumes the serialiser outside takes one message per tx valid pulse and
  that rx valid pulses carry complete, checked messages.
*/
`timescale 1ns/1ps
`default_nettype none

module psr_messenger #(
  parameter int unsigned INTEG_CYC = psr_pkg::INTEGRITY_CYC,
  parameter int unsigned RET_CYC = psr_pkg::RETURN_CYC,
  parameter int unsigned OFF_CYC = psr_pkg::OFFLINE_CYC,
  parameter int unsigned FRM_FAST_CYC = psr_pkg::FRAME_FAST_CYC,
  parameter int unsigned FRM_SLOW_CYC = psr_pkg::FRAME_SLOW_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scan_pulse,
  input wire logic [psr_pkg::DATA_W-1:0] status_in,
  input wire logic [psr_pkg::ID_W-1:0] sender_identifier,
  input wire logic dual_channel,
  input wire logic ring_enable,
  input wire logic rate_fast_sel,
  input wire logic fiber_card,
  input wire logic fixed_rate_module,
  input wire logic channel_bridge_enable,
  input wire logic [psr_pkg::PEERS-1:0][psr_pkg::ID_W-1:0] peer_id,
  input wire logic [psr_pkg::PEERS-1:0] peer_enable,
  input wire psr_pkg::psr_port_s [psr_pkg::CHANS-1:0] rx_port,
  output var psr_pkg::psr_port_s [psr_pkg::CHANS-1:0] tx_port,
  output var logic link_fast,
  output var logic ring_break,
  output var logic [psr_pkg::PEERS-1:0] peer_offline
);
  import psr_pkg::*;

  // Integrity request leads by one slow frame so a busy channel cannot push it late
  localparam logic [TMR_W-1:0] INTEG_TRIG = TMR_W'(INTEG_CYC - FRM_SLOW_CYC - 2);
  localparam logic [TMR_W-1:0] RET_LIM = TMR_W'(RET_CYC - 1);
  localparam logic [TMR_W-1:0] OFF_LIM = TMR_W'(OFF_CYC - 1);

  logic [CHANS-1:0] chan_on;
  logic [CHANS-1:0] busy;
  logic [CHANS-1:0] start;
  logic [CHANS-1:0] fwd_fire;
  logic [CHANS-1:0] ret_hit;
  logic [CHANS-1:0] load_v;
  psr_msg_s load_m [CHANS];
  logic [CHANS-1:0] fwd_pend;
  psr_msg_s fwd_msg [CHANS];
  logic own_req;
  logic own_fire;
  logic own_tx;
  logic change_evt;
  logic [DATA_W-1:0] last_status;
  logic [TMR_W-1:0] integ_cnt;
  logic ret_wait;
  logic [CHANS-1:0] ret_seen;
  logic [TMR_W-1:0] ret_cnt;
  logic [TMR_W-1:0] peer_cnt [PEERS];

  // ------------------------------------------------------------
  // Rate and channel selection
  // ------------------------------------------------------------
  // The fixed-rate modules ignore the rate setting entirely
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_fast <= 1'b0;
    end else begin
      link_fast <= rate_fast_sel && fiber_card && !fixed_rate_module; // [R11] [R14] [R12]
    end
  end

  assign chan_on = {dual_channel, 1'b1}; // [R2]

  // ------------------------------------------------------------
  // Scheduling
  // ------------------------------------------------------------
  assign change_evt = scan_pulse && (status_in != last_status);
  // Own messages wait until every live channel is free, keeping both copies aligned
  assign own_fire = own_req && ((busy & chan_on) == '0); // [R1]

  always_comb begin
    for (int c = 0; c < CHANS; c++) begin
      // Ids are distinct across the ring, so a match is our own return [R9]
      ret_hit[c] = rx_port[c].valid && psr_id_match(rx_port[c].msg.sender, sender_identifier); // [R17]
      load_v[c] = rx_port[c].valid && chan_on[c] && !ret_hit[c]; // [R3]
      load_m[c] = rx_port[c].msg;
      fwd_fire[c] = fwd_pend[c] && !busy[c] && chan_on[c] && !own_fire;
      start[c] = (own_fire && chan_on[c]) || fwd_fire[c]; // [R1] [R2]
    end
    // Bridge shares the second slot; the channel's own traffic has priority
    if (!load_v[1] && load_v[0] && dual_channel && channel_bridge_enable) begin
      load_v[1] = 1'b1; // [R15]
      load_m[1] = rx_port[0].msg;
    end
  end

  // ------------------------------------------------------------
  // Own message request
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_req <= 1'b0;
    end else if (change_evt || integ_cnt == INTEG_TRIG) begin
      own_req <= 1'b1; // [R5] [R4]
    end else if (own_fire) begin
      own_req <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_cnt <= '0;
    end else if (own_fire) begin
      integ_cnt <= '0;
    end else if (integ_cnt != INTEG_TRIG) begin
      integ_cnt <= integ_cnt + 1'b1; // [R4]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_status <= '0;
    end else if (own_fire) begin
      last_status <= status_in;
    end
  end

  // ------------------------------------------------------------
  // Forward slots and channel timers
  // ------------------------------------------------------------
  generate
    for (genvar c = 0; c < CHANS; c++) begin : g_chan
      // A newer message overwrites an unsent one; status is state, not history
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          fwd_pend[c] <= 1'b0;
          fwd_msg[c] <= '0;
        end else if (load_v[c]) begin
          fwd_pend[c] <= 1'b1; // [R3]
          fwd_msg[c] <= load_m[c];
        end else if (fwd_fire[c] || !chan_on[c]) begin
          fwd_pend[c] <= 1'b0;
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          tx_port[c] <= '0;
        end else begin
          tx_port[c].valid <= start[c];
          if (own_fire) begin
            tx_port[c].msg <= '{sender: sender_identifier, status: status_in}; // [R8]
          end else if (fwd_fire[c]) begin
            tx_port[c].msg <= fwd_msg[c];
          end
        end
      end

      psr_chan_pacer #(
        .FAST_CYC(FRM_FAST_CYC),
        .SLOW_CYC(FRM_SLOW_CYC)
      ) u_pacer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .rate_fast(link_fast), // [R13]
        .start(start[c]),
        .busy(busy[c])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_tx <= 1'b0;
    end else begin
      own_tx <= own_fire;
    end
  end

  // ------------------------------------------------------------
  // Ring break watch
  // ------------------------------------------------------------
  // Each live channel must bring the message back before the timeout
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_wait <= 1'b0;
      ret_seen <= '0;
      ret_cnt <= '0;
      ring_break <= 1'b0;
    end else if (!ring_enable) begin
      ret_wait <= 1'b0; // [R10]
      ring_break <= 1'b0;
    end else if (ret_wait) begin
      if (ret_cnt == RET_LIM) begin
        ret_wait <= 1'b0;
        ring_break <= ((ret_seen | ret_hit) & chan_on) != chan_on; // [R6]
      end else if (((ret_seen | ret_hit) & chan_on) == chan_on) begin
        ret_wait <= 1'b0;
        ring_break <= 1'b0;
      end else begin
        ret_cnt <= ret_cnt + 1'b1;
        ret_seen <= ret_seen | ret_hit;
      end
    end else if (own_fire) begin
      ret_wait <= 1'b1; // [R10]
      ret_seen <= '0;
      ret_cnt <= '0;
    end
  end

  // ------------------------------------------------------------
  // Peer liveness
  // ------------------------------------------------------------
  // Port passed in so the checks see sampled values, not post-edge ones
  function automatic logic peer_heard(input psr_port_s [CHANS-1:0] rx, input logic [ID_W-1:0] id);
    logic hit;
    hit = 1'b0;
    for (int c = 0; c < CHANS; c++) begin
      hit = hit || (rx[c].valid && psr_id_match(rx[c].msg.sender, id));
    end
    return hit;
  endfunction

  generate
    for (genvar k = 0; k < PEERS; k++) begin : g_peer
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          peer_cnt[k] <= '0;
          peer_offline[k] <= 1'b0;
        end else if (!peer_enable[k] || peer_heard(rx_port, peer_id[k])) begin
          peer_cnt[k] <= '0;
          peer_offline[k] <= 1'b0;
        end else if (peer_cnt[k] == OFF_LIM) begin
          peer_offline[k] <= 1'b1; // [R7]
        end else begin
          peer_cnt[k] <= peer_cnt[k] + 1'b1;
        end
      end

      property p_peer_alive;
        @(posedge sys_clk) disable iff (!rst_n)
        peer_enable[k] && peer_heard(rx_port, peer_id[k]) |=> !peer_offline[k] && peer_cnt[k] == '0;
      endproperty
      a_peer_alive: assert property (p_peer_alive) else $error("heard peer shown offline"); // [R7]
    end
  endgenerate

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_dual_both;
    @(posedge sys_clk) disable iff (!rst_n)
    own_fire && dual_channel |=> tx_port[0].valid && tx_port[1].valid
      && tx_port[0].msg == tx_port[1].msg;
  endproperty
  a_dual_both: assert property (p_dual_both) else $error("dual send not aligned"); // [R1]

  property p_single_only;
    @(posedge sys_clk) disable iff (!rst_n)
    !dual_channel && $past(!dual_channel, 2) |-> !tx_port[1].valid;
  endproperty
  a_single_only: assert property (p_single_only) else $error("second channel used"); // [R2]

  property p_no_self_fwd;
    @(posedge sys_clk) disable iff (!rst_n)
    $stable(sender_identifier) && tx_port[0].valid && !own_tx
      |-> tx_port[0].msg.sender != sender_identifier;
  endproperty
  a_no_self_fwd: assert property (p_no_self_fwd) else $error("own message forwarded"); // [R3]

  property p_integrity;
    @(posedge sys_clk) disable iff (!rst_n)
    integ_cnt == INTEG_TRIG |=> own_req;
  endproperty
  a_integrity: assert property (p_integrity) else $error("integrity request missing"); // [R4]

  property p_change_send;
    @(posedge sys_clk) disable iff (!rst_n)
    change_evt && (busy & chan_on) == '0 && start == '0 |=> own_req ##1 own_tx;
  endproperty
  a_change_send: assert property (p_change_send) else $error("change not sent"); // [R5]

  property p_sender_tag;
    @(posedge sys_clk) disable iff (!rst_n)
    own_fire |=> tx_port[0].msg.sender == $past(sender_identifier)
      && tx_port[0].msg.status == $past(status_in);
  endproperty
  a_sender_tag: assert property (p_sender_tag) else $error("sender tag wrong"); // [R8]

  property p_ring_off;
    @(posedge sys_clk) disable iff (!rst_n)
    !ring_enable |=> !ring_break && !ret_wait;
  endproperty
  a_ring_off: assert property (p_ring_off) else $error("ring check while disabled"); // [R10]

  property p_fixed_rate;
    @(posedge sys_clk) disable iff (!rst_n)
    fixed_rate_module || !fiber_card |=> !link_fast;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fast rate on slow module"); // [R14]

  property p_bridge;
    @(posedge sys_clk) disable iff (!rst_n)
    dual_channel && channel_bridge_enable && load_v[0] && !rx_port[1].valid
      |=> fwd_pend[1] && fwd_msg[1] == $past(rx_port[0].msg);
  endproperty
  a_bridge: assert property (p_bridge) else $error("bridge did not copy"); // [R15]

  c_dual_send: cover property (@(posedge sys_clk) disable iff (!rst_n) own_fire && dual_channel);
  c_ring_break: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(ring_break));
  c_peer_off: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(peer_offline[0]));
  c_bridge: cover property (@(posedge sys_clk) disable iff (!rst_n) fwd_fire[1] && channel_bridge_enable);

endmodule

`default_nettype wire

// [src/psr_pkg.sv]
/*
  Constants, message carrier and timing for the peer status ring messenger.
  Assumes a single 40 MHz system clock; serialisation of a message onto the
  wire is done outside, one message word per valid cycle.
*/
// Contract
// R1 - With two channels, each own message leaves on both channels together.
// R2 - With one channel, own messages leave on the first channel only.
// R3 - Messages from other senders are forwarded; own messages are never forwarded.
// R4 - An integrity message goes out at most 1000 ms after the previous one.
// R5 - A changed status is sent in the same scan pass unless bandwidth is used up.
// R6 - Ring break flag rises when own messages do not come back.
// R7 - Up to 16 configured peers each have an offline flag when silent.
// R8 - Every own message carries the configured sender identifier.
// R9 - All ring nodes must use distinct sender identifiers.
// R10 - Ring break checking runs only with the ring setting on.
// R11 - 128 kbps only on fiber back-to-back cards, 64 kbps otherwise.
// R12 - All nodes on the network must use the same link rate.
// R13 - Both channels of a dual card share the one configured rate.
// R14 - Telecom and differential serial modules stay fixed at 64 kbps.
// R15 - Channel bridge passes messages received on channel one to channel two.
// R16 - Each hop adds about 0.2 cycle at high rate, 0.4 at low.
// R17 - Received sender identifier against own decides forward or own return.
`default_nettype none

package psr_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned ID_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PEERS = 16;
  localparam int unsigned CHANS = 2;
  localparam int unsigned TMR_W = 27;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned INTEGRITY_MS = 1000;
  localparam int unsigned INTEGRITY_CYC = SYS_CLK_HZ / 1000 * INTEGRITY_MS;
  localparam int unsigned RETURN_MS = 100;
  localparam int unsigned RETURN_CYC = SYS_CLK_HZ / 1000 * RETURN_MS;
  localparam int unsigned OFFLINE_MS = 2000;
  localparam int unsigned OFFLINE_CYC = SYS_CLK_HZ / 1000 * OFFLINE_MS;
  localparam int unsigned RATE_FAST_BPS = 128_000;
  localparam int unsigned RATE_SLOW_BPS = 64_000;
  localparam int unsigned BIT_FAST_CYC = (SYS_CLK_HZ + RATE_FAST_BPS - 1) / RATE_FAST_BPS;
  localparam int unsigned BIT_SLOW_CYC = (SYS_CLK_HZ + RATE_SLOW_BPS - 1) / RATE_SLOW_BPS;
  localparam int unsigned MSG_BITS = 160;
  localparam int unsigned FRAME_FAST_CYC = BIT_FAST_CYC * MSG_BITS;
  localparam int unsigned FRAME_SLOW_CYC = BIT_SLOW_CYC * MSG_BITS;

  // ------------------------------------------------------------
  // Carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ID_W-1:0] sender;
    logic [DATA_W-1:0] status;
  } psr_msg_s;

  typedef struct packed {
    logic valid;
    psr_msg_s msg;
  } psr_port_s;

  function automatic logic psr_id_match(input logic [ID_W-1:0] a, input logic [ID_W-1:0] b);
    return a == b;
  endfunction

endpackage

`default_nettype wire

// [tb/peer_status_ring_messenger_tb.sv]
/*
  Self-checking bench for the peer status ring messenger.
  Assumes shortened frame and timer parameters; the ring partner model
  sits on the rx side.
*/
`timescale 1ns/1ps
`default_nettype none

module peer_status_ring_messenger_tb;
  import psr_pkg::*;

  localparam int unsigned FF = 8, FS = 16, IC = 200, RC = 60, OC = 400;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scan_pulse = 1'b0;
  logic [DATA_W-1:0] status_in = '0;
  logic [ID_W-1:0] own_id = 8'h2A;
  logic dual_channel = 1'b0, ring_enable = 1'b0, bridge_en = 1'b0;
  logic rate_fast_sel = 1'b0, fiber_card = 1'b0, fixed_rate_module = 1'b0;
  logic [PEERS-1:0][ID_W-1:0] peer_id;
  logic [PEERS-1:0] peer_enable = 16'h0008;
  logic [CHANS-1:0] loop_en = 2'b11;
  psr_port_s [CHANS-1:0] inj_port = '0;
  psr_port_s [CHANS-1:0] rx_port, tx_port;
  logic link_fast, ring_break, hit;
  logic [PEERS-1:0] peer_offline;
  int num_errors = 0, n_tests = 0;

  always #12.5 sys_clk = ~sys_clk;

  psr_messenger #(.INTEG_CYC(IC), .RET_CYC(RC), .OFF_CYC(OC),
    .FRM_FAST_CYC(FF), .FRM_SLOW_CYC(FS)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scan_pulse(scan_pulse), .status_in(status_in),
    .sender_identifier(own_id), .dual_channel(dual_channel), .ring_enable(ring_enable),
    .rate_fast_sel(rate_fast_sel), .fiber_card(fiber_card),
    .fixed_rate_module(fixed_rate_module), .channel_bridge_enable(bridge_en),
    .peer_id(peer_id), .peer_enable(peer_enable), .rx_port(rx_port), .tx_port(tx_port),
    .link_fast(link_fast), .ring_break(ring_break), .peer_offline(peer_offline));

  psr_ring_partner #(.HOP(4)) partner (
    .sys_clk(sys_clk), .rst_n(rst_n), .own_id(own_id), .loop_en(loop_en),
    .inj_port(inj_port), .tx_port(tx_port), .rx_port(rx_port));

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic scan(input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    status_in <= v;
    scan_pulse <= 1'b1;
    @(posedge sys_clk);
    scan_pulse <= 1'b0;
  endtask

  task automatic inject(input int ch, input logic [ID_W-1:0] id, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    inj_port[ch] <= {1'b1, id, v};
    @(posedge sys_clk);
    inj_port[ch] <= '0;
  endtask

  // Stops at the first pulse carrying exactly m; hit stays low otherwise
  task automatic wait_tx(input int ch, input int maxc, input psr_msg_s m);
    hit = 1'b0;
    for (int i = 0; i < maxc && !hit; i++) begin
      @(posedge sys_clk);
      #1;
      hit = (tx_port[ch] === {1'b1, m});
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    // Ids distinct from the node's own
    for (int k = 0; k < PEERS; k++) peer_id[k] = 8'h40 + 8'(k);
    peer_id[3] = 8'h07;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    cyc(OC + 10);
    chk("peer_offline silent", 64'h0008, 64'(peer_offline));
    inject(0, 8'h07, 32'h0000_00A5);
    wait_tx(0, 40, {8'h07, 32'h0000_00A5});
    chk("forward peer msg", 64'h1, 64'(hit));
    chk("peer_offline heard", 64'h0, 64'(peer_offline));
    inject(0, own_id, 32'hDEAD_0001);
    wait_tx(0, 30, {own_id, 32'hDEAD_0001});
    chk("own msg not forwarded", 64'h0, 64'(hit));
    scan(32'h1234_5678);
    wait_tx(0, 40, {own_id, 32'h1234_5678});
    chk("single send", 64'h1, 64'(hit));
    chk("single tx1 idle", 64'h0, 64'(tx_port[1].valid));
    @(posedge sys_clk);
    dual_channel <= 1'b1;
    scan(32'h8765_4321);
    wait_tx(0, 40, {own_id, 32'h8765_4321});
    chk("dual send", 64'h1, 64'(hit));
    chk("dual tx1 pair", 64'({1'b1, own_id, 32'h8765_4321}), 64'(tx_port[1]));
    // No change: only the integrity message can satisfy this wait
    wait_tx(0, IC, {own_id, 32'h8765_4321});
    chk("integrity send", 64'h1, 64'(hit));
    @(posedge sys_clk);
    bridge_en <= 1'b1;
    inject(0, 8'h09, 32'h0000_0B0B);
    wait_tx(1, 40, {8'h09, 32'h0000_0B0B});
    chk("bridge ch0 to ch1", 64'h1, 64'(hit));
    @(posedge sys_clk);
    bridge_en <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      {rate_fast_sel, fiber_card, fixed_rate_module} <= 3'(i);
      cyc(3);
      chk("link_fast", 64'(i == 6), 64'(link_fast));
    end
    // Fast rate on both channels: a second change waits only one fast frame
    @(posedge sys_clk);
    {rate_fast_sel, fiber_card, fixed_rate_module} <= 3'b110;
    cyc(3);
    scan(32'h0000_0A0A);
    wait_tx(1, 40, {own_id, 32'h0000_0A0A});
    chk("fast first send", 64'h1, 64'(hit));
    scan(32'h0000_0B0C);
    wait_tx(1, FF + 2, {own_id, 32'h0000_0B0C});
    chk("fast frame spacing", 64'h1, 64'(hit));
    @(posedge sys_clk);
    ring_enable <= 1'b1;
    scan(32'h0000_0001);
    cyc(FS + RC + 30);
    chk("ring whole", 64'h0, 64'(ring_break));
    @(posedge sys_clk);
    loop_en <= 2'b10;
    scan(32'h0000_0002);
    cyc(FS + RC + 30);
    chk("ring broken ch0", 64'h1, 64'(ring_break));
    @(posedge sys_clk);
    ring_enable <= 1'b0;
    cyc(3);
    chk("ring off clears", 64'h0, 64'(ring_break));
    cyc(IC + RC);
    chk("ring off stays", 64'h0, 64'(ring_break));
    final_report();
  end

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  // Tests need about 1200 cycles; the margin covers busy channels
  initial begin
    cyc(5000);
    num_errors++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    final_report();
  end
endmodule

`default_nettype wire

// [tb/psr_ring_partner.sv]
/*
  Far side of the ring: returns the node's own messages after one hop and
  injects peer messages on command.
  Assumes own sends on a channel are at least HOP+1 cycles apart.
*/
`timescale 1ns/1ps
`default_nettype none

module psr_ring_partner #(
  parameter int unsigned HOP = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [psr_pkg::ID_W-1:0] own_id,
  input wire logic [psr_pkg::CHANS-1:0] loop_en,
  input wire psr_pkg::psr_port_s [psr_pkg::CHANS-1:0] inj_port,
  input wire psr_pkg::psr_port_s [psr_pkg::CHANS-1:0] tx_port,
  output var psr_pkg::psr_port_s [psr_pkg::CHANS-1:0] rx_port
);
  import psr_pkg::*;

  psr_msg_s held [CHANS];
  logic [7:0] dly [CHANS];

  // ------------------------------------------------------------
  // Return path
  // ------------------------------------------------------------
  // Peers drop what they sent, so only the node's own messages come back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_port <= '0;
      for (int c = 0; c < CHANS; c++) begin
        held[c] <= '0;
        dly[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (tx_port[c].valid && tx_port[c].msg.sender == own_id) begin
          held[c] <= tx_port[c].msg;
          dly[c] <= 8'(HOP); // one hop of latency
        end else if (dly[c] != 8'h00) begin
          dly[c] <= dly[c] - 8'h01;
        end
        // Idle lines toggle so a stale message never looks valid
        if (inj_port[c].valid) begin
          rx_port[c] <= inj_port[c];
        end else if (loop_en[c] && dly[c] == 8'h01) begin
          rx_port[c] <= {1'b1, held[c]};
        end else begin
          rx_port[c] <= {1'b0, ~rx_port[c].msg};
        end
      end
    end
  end
endmodule

`default_nettype wire
